/* src/oscillator_source_and_tuning.sv */
/*
  Oscillator source selection, loop gain, fast RC trim, lock status and
  low-power RC enable control with a register port.
  Assumes the analog loop supplies an asynchronous lock level and that
  srst_i is the power-on reset.
*/
// Operation
// - Loop gain is x4, x8 or x16
// - Lock indication follows the loop lock while the loop is enabled
// - Lock status readable, writes ignored
// - Select code 01 runs from fast RC
// - Four-bit trim, zero is calibrated frequency
// - Trim is signed 1.5 percent steps
// - Low RC clocks delay, watchdog, monitor
// - Low RC forced on at power-on
// - After delay, low RC kept only if needed
// - Crystal clock needs select 00 and enable
`timescale 1ns/1ns
module oscillator_source_and_tuning
  import osc_ctrl_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_COUNT = osc_ctrl_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  // Register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // Loop
  input  wire logic        pll_lock_raw_i,
  output logic             pll_enable_o,
  output logic [1:0]       pll_gain_o,
  // Oscillator controls
  output logic [1:0]       clock_select_o,
  output logic             fast_rc_select_o,
  output logic             low_power_crystal_clock_o,
  output logic             low_power_crystal_run_o,
  output logic [3:0]       fast_rc_trim_o,
  output logic signed [7:0] fast_rc_offset_permil_o,
  output logic             low_rc_enable_o,
  output logic             timers_clock_en_o,
  output logic             power_up_delay_timer_done_o
);
  import osc_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [1:0] current_osc_select_reg;
  logic [3:0] fast_rc_trim_reg;
  logic       low_power_crystal_enable_reg;
  logic       pll_en_reg;
  logic [1:0] gain_reg;
  logic       fscm_en_reg;
  logic       wdog_en_reg;
  logic       lock_level;
  logic       lock_reg;
  pwr_state_t pwr_reg;
  logic [31:0] power_up_delay_timer_cnt_reg;

  function automatic logic [1:0] legal_gain(input logic [1:0] g);
    legal_gain = (g == GAIN_X8 || g == GAIN_X16) ? g : GAIN_X4;
  endfunction

  function automatic logic signed [7:0] trim_permil(input logic [3:0] t);
    trim_permil = 8'(signed'({{4{t[3]}}, t}) * 8'(TRIM_STEP_PERMIL));
  endfunction

  lock_sync u_lock_sync (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .raw_i   (pll_lock_raw_i),
    .level_o (lock_level)
  );

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      current_osc_select_reg       <= SEL_RESET;
      fast_rc_trim_reg             <= TRIM_RESET;
      low_power_crystal_enable_reg <= 1'b0;
    end else if (wr_i && addr_i == ADDR_OSC_CTRL) begin
      current_osc_select_reg       <= wdata_i[SEL_HI:SEL_LO];
      fast_rc_trim_reg             <= wdata_i[TRIM_HI:TRIM_LO];
      low_power_crystal_enable_reg <= wdata_i[LPXTAL_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pll_en_reg <= 1'b0;
      gain_reg   <= GAIN_RESET;
    end else if (wr_i && addr_i == ADDR_PLL_CFG) begin
      pll_en_reg <= wdata_i[PLL_EN_BIT];
      gain_reg   <= legal_gain(wdata_i[GAIN_HI:GAIN_LO]);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fscm_en_reg <= 1'b0;
      wdog_en_reg <= 1'b0;
    end else if (wr_i && addr_i == ADDR_MISC_CFG) begin
      fscm_en_reg <= wdata_i[FSCM_BIT];
      wdog_en_reg <= wdata_i[WDOG_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Lock status
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= lock_level && pll_en_reg;
    end
  end

  // ---------------------------------------------------------------
  // Power-up delay and low RC enable
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pwr_reg      <= PWR_RESET;
      power_up_delay_timer_cnt_reg <= 32'h0;
    end else begin
      case (pwr_reg)
        PWR_RESET: begin
          pwr_reg      <= PWR_TIMING;
          power_up_delay_timer_cnt_reg <= 32'h0;
        end
        PWR_TIMING: begin
          if (power_up_delay_timer_cnt_reg >= 32'(POWER_UP_DELAY_TIMER_COUNT - 1)) begin
            pwr_reg <= PWR_RUN;
          end
          power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg + 32'h1;
        end
        default: begin
          pwr_reg <= PWR_RUN;
        end
      endcase
    end
  end

  logic low_rc_needed;
  assign low_rc_needed = fscm_en_reg || wdog_en_reg ||
                         current_osc_select_reg == SEL_LOW_RC;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      low_rc_enable_o   <= 1'b1;
      timers_clock_en_o <= 1'b1;
      power_up_delay_timer_done_o       <= 1'b0;
    end else begin
      low_rc_enable_o   <= (pwr_reg != PWR_RUN) || low_rc_needed;
      timers_clock_en_o <= (pwr_reg != PWR_RUN) || low_rc_needed;
      power_up_delay_timer_done_o       <= (pwr_reg == PWR_RUN);
    end
  end

  // ---------------------------------------------------------------
  // Clock source outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      clock_select_o            <= SEL_RESET;
      fast_rc_select_o          <= 1'b1;
      low_power_crystal_clock_o <= 1'b0;
      low_power_crystal_run_o   <= 1'b0;
      fast_rc_trim_o            <= TRIM_RESET;
      fast_rc_offset_permil_o   <= 8'sh0;
      pll_enable_o              <= 1'b0;
      pll_gain_o                <= GAIN_RESET;
    end else begin
      clock_select_o            <= current_osc_select_reg;
      fast_rc_select_o          <= current_osc_select_reg == SEL_FAST_RC;
      low_power_crystal_clock_o <= current_osc_select_reg == SEL_LP_CRYSTAL &&
                                   low_power_crystal_enable_reg;
      low_power_crystal_run_o   <= low_power_crystal_enable_reg;
      fast_rc_trim_o            <= fast_rc_trim_reg;
      fast_rc_offset_permil_o   <= trim_permil(fast_rc_trim_reg);
      pll_enable_o              <= pll_en_reg;
      pll_gain_o                <= gain_reg;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0;
    end else if (rd_i) begin
      if (addr_i == ADDR_OSC_CTRL) begin
        rdata_o <= {2'h0, current_osc_select_reg, fast_rc_trim_reg, 2'h0,
                    lock_reg, 3'h0, low_power_crystal_enable_reg, 1'b0};
      end else if (addr_i == ADDR_PLL_CFG) begin
        rdata_o <= {13'h0, gain_reg, pll_en_reg};
      end else if (addr_i == ADDR_MISC_CFG) begin
        rdata_o <= {14'h0, wdog_en_reg, fscm_en_reg};
      end else begin
        rdata_o <= 16'h0;
      end
    end else begin
      rdata_o <= 16'h0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_gain_legal: assert property (@(posedge clock_i) disable iff (srst_i)
    pll_gain_o != 2'h3) else $error("illegal loop gain");
  a_lock_follows: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(lock_level) && pll_en_reg |=> lock_reg) else $error("lock late");
  a_lock_readonly: assert property (@(posedge clock_i) disable iff (srst_i)
    wr_i && addr_i == ADDR_OSC_CTRL && !lock_level |=> !lock_reg)
    else $error("lock writable");
  a_fast_rc_sel: assert property (@(posedge clock_i) disable iff (srst_i)
    wr_i && addr_i == ADDR_OSC_CTRL && wdata_i[SEL_HI:SEL_LO] == SEL_FAST_RC
    |=> ##1 fast_rc_select_o) else $error("fast rc not chosen");
  a_trim_zero: assert property (@(posedge clock_i) disable iff (srst_i)
    fast_rc_trim_o == 4'h0 |-> fast_rc_offset_permil_o == 8'sh0)
    else $error("zero trim offset");
  a_trim_min: assert property (@(posedge clock_i) disable iff (srst_i)
    fast_rc_trim_o == 4'h8 |-> fast_rc_offset_permil_o == -8'sd120)
    else $error("trim floor wrong");
  a_low_rc_timing: assert property (@(posedge clock_i) disable iff (srst_i)
    pwr_reg == PWR_TIMING |=> low_rc_enable_o) else $error("low rc off early");
  a_low_rc_off: assert property (@(posedge clock_i) disable iff (srst_i)
    pwr_reg == PWR_RUN && !low_rc_needed |=> !low_rc_enable_o)
    else $error("low rc left on");
  a_timer_clock: assert property (@(posedge clock_i) disable iff (srst_i)
    timers_clock_en_o == low_rc_enable_o) else $error("timer clock gap");
  a_crystal_sel: assert property (@(posedge clock_i) disable iff (srst_i)
    low_power_crystal_clock_o |-> clock_select_o == SEL_LP_CRYSTAL &&
    low_power_crystal_run_o) else $error("crystal select wrong");
  a_lock_loop_off: assert property (@(posedge clock_i) disable iff (srst_i)
    !pll_en_reg |=> !lock_reg) else $error("lock with loop off");
endmodule

/* src/osc_ctrl_pkg.sv */
/*
  Constants for the oscillator source and tuning control block.
  Assumes a single 250 MHz system clock and a plain register port.
*/
package osc_ctrl_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PLL_CFG  = 4'h4;
  localparam logic [3:0] ADDR_MISC_CFG = 4'h8;
  // ---------------------------------------------------------------
  // Oscillator control, loop and misc register fields
  // ---------------------------------------------------------------
  localparam int SEL_HI      = 13;
  localparam int SEL_LO      = 12;
  localparam int TRIM_HI     = 11;
  localparam int TRIM_LO     = 8;
  localparam int LOCK_BIT    = 5;
  localparam int LPXTAL_BIT  = 1;
  localparam int PLL_EN_BIT  = 0;
  localparam int GAIN_HI     = 2;
  localparam int GAIN_LO     = 1;
  localparam int FSCM_BIT    = 0;
  localparam int WDOG_BIT    = 1;
  // ---------------------------------------------------------------
  // Selection codes and gains
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_LP_CRYSTAL = 2'h0;
  localparam logic [1:0] SEL_FAST_RC    = 2'h1;
  localparam logic [1:0] SEL_PRIMARY    = 2'h2;
  localparam logic [1:0] SEL_LOW_RC     = 2'h3;
  localparam logic [1:0] GAIN_X4        = 2'h0;
  localparam logic [1:0] GAIN_X8        = 2'h1;
  localparam logic [1:0] GAIN_X16       = 2'h2;
  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [1:0]  SEL_RESET       = 2'h1;
  localparam logic [3:0]  TRIM_RESET      = 4'h0;
  localparam logic [1:0]  GAIN_RESET      = 2'h0;
  localparam int          CLOCK_MHZ       = 250;
  localparam int          POWER_UP_DELAY_TIMER_TIME_US    = 64;
  localparam int          POWER_UP_DELAY_TIMER_CYCLES     = POWER_UP_DELAY_TIMER_TIME_US * CLOCK_MHZ;
  localparam int          FAST_RC_KHZ     = 7370;
  localparam int          LOW_RC_KHZ      = 512;
  localparam int          TRIM_STEP_PERMIL = 15;
  typedef enum logic [1:0] {
    PWR_RESET   = 2'b00,
    PWR_TIMING  = 2'b01,
    PWR_RUN     = 2'b10
  } pwr_state_t;
endpackage

/* src/lock_sync.sv */
/*
  Three-stage synchroniser with agreement filter for the loop lock pin.
  Assumes the lock input is asynchronous to clock_i.
*/
`timescale 1ns/1ns
module lock_sync (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  // Raw and filtered level
  input  wire logic raw_i,
  output logic      level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= raw_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      level_o <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_o <= s3_reg;
    end
  end
endmodule

/* verification/tb.sv */
/*
  Self-checking testbench for the oscillator source and tuning block.
  Assumes the design sources and osc_ctrl_pkg are compiled first.
*/
`timescale 1ns/1ns
module tb;
  import osc_ctrl_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int POWER_UP_DELAY_TIMER_SIM = 20;
  logic               clock_i;
  logic               srst_i;
  logic [3:0]         addr_i;
  logic [15:0]        wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic [15:0]        rdata_o;
  logic               pll_lock_raw_i;
  logic               pll_enable_o;
  logic [1:0]         pll_gain_o;
  logic [1:0]         clock_select_o;
  logic               fast_rc_select_o;
  logic               xtal_clk;
  logic               xtal_run;
  logic [3:0]         fast_rc_trim_o;
  logic signed [7:0]  offset;
  logic               low_rc_enable_o;
  logic               timers_clock_en_o;
  logic               power_up_delay_timer_done_o;
  logic [15:0]        rd_val;
  int                 error_cnt;
  int                 checked;
  int                 cycles;

  oscillator_source_and_tuning #(.POWER_UP_DELAY_TIMER_COUNT(POWER_UP_DELAY_TIMER_SIM)) dut (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pll_lock_raw_i(pll_lock_raw_i),
    .pll_enable_o(pll_enable_o), .pll_gain_o(pll_gain_o),
    .clock_select_o(clock_select_o), .fast_rc_select_o(fast_rc_select_o),
    .low_power_crystal_clock_o(xtal_clk), .low_power_crystal_run_o(xtal_run),
    .fast_rc_trim_o(fast_rc_trim_o), .fast_rc_offset_permil_o(offset),
    .low_rc_enable_o(low_rc_enable_o), .timers_clock_en_o(timers_clock_en_o),
    .power_up_delay_timer_done_o(power_up_delay_timer_done_o));

  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial clock_i = 1'b0;
  always #2 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask

  task automatic wait_lock(input logic exp);
    for (int n = 0; n < 20; n++) begin
      rd(ADDR_OSC_CTRL);
      if (rd_val[LOCK_BIT] === exp)
        break;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic reset_test();
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    check(16'(clock_select_o), 16'(SEL_FAST_RC));
    check(16'(fast_rc_select_o), 16'h0001);
    check(16'(fast_rc_trim_o), 16'h0000);
    check(16'(pll_enable_o), 16'h0000);
    check(16'(pll_gain_o), 16'(GAIN_RESET));
    check(16'({power_up_delay_timer_done_o, low_rc_enable_o, timers_clock_en_o}), 16'h0003);
    rd(ADDR_OSC_CTRL);
    check(16'(rd_val[LOCK_BIT]), 16'h0000);
  endtask

  task automatic power_up_delay_timer_test();
    for (int n = 0; n < POWER_UP_DELAY_TIMER_SIM + 10 && power_up_delay_timer_done_o !== 1'b1; n++) begin
      check(16'(low_rc_enable_o), 16'h0001);
      @(posedge clock_i);
      #1;
    end
    check(16'(power_up_delay_timer_done_o), 16'h0001);
    repeat (2) @(posedge clock_i);
    #1;
    check(16'({low_rc_enable_o, timers_clock_en_o}), 16'h0000);
    for (int m = 1; m < 5; m++) begin
      wr(ADDR_MISC_CFG, 16'(m & 3));
      check(16'({low_rc_enable_o, timers_clock_en_o}), (m & 3) ? 16'h3 : 16'h0);
    end
    wr(ADDR_OSC_CTRL, 16'h3000);
    check(16'(low_rc_enable_o), 16'h0001);
  endtask

  task automatic select_test();
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 2; c++) begin
        wr(ADDR_OSC_CTRL, 16'((s << SEL_LO) | (c << LPXTAL_BIT)));
        check(16'(clock_select_o), 16'(s));
        check(16'(fast_rc_select_o), 16'(s == 1));
        check(16'({xtal_clk, xtal_run}), 16'({(s == 0 && c == 1), c[0]}));
        check(16'(low_rc_enable_o), 16'(s == 3));
      end
    end
  endtask

  task automatic trim_test();
    int v;
    for (int t = 0; t < 16; t++) begin
      v = (t > 7) ? t - 16 : t;
      wr(ADDR_OSC_CTRL, 16'(16'h1000 | (t << TRIM_LO)));
      check(16'(fast_rc_trim_o), 16'(t));
      check({8'h00, offset}, {8'h00, 8'(v * TRIM_STEP_PERMIL)});
      rd(ADDR_OSC_CTRL);
      check(rd_val & 16'h3f00, 16'(16'h1000 | (t << TRIM_LO)));
    end
  endtask

  task automatic gain_lock_test();
    for (int g = 0; g < 4; g++) begin
      wr(ADDR_PLL_CFG, 16'((g << GAIN_LO) | 1));
      check(16'({pll_enable_o, pll_gain_o}), 16'({1'b1, (g == 3) ? 2'h0 : 2'(g)}));
      rd(ADDR_PLL_CFG);
      check(rd_val, 16'((((g == 3) ? 0 : g) << GAIN_LO) | 1));
    end
    @(posedge clock_i);
    pll_lock_raw_i <= 1'b1;
    wait_lock(1'b1);
    check(16'(rd_val[LOCK_BIT]), 16'h0001);
    wr(ADDR_OSC_CTRL, 16'h1000);
    rd(ADDR_OSC_CTRL);
    check(16'(rd_val[LOCK_BIT]), 16'h0001);
    @(posedge clock_i);
    pll_lock_raw_i <= 1'b0;
    wait_lock(1'b0);
    check(16'(rd_val[LOCK_BIT]), 16'h0000);
    wr(ADDR_OSC_CTRL, 16'h1020);
    rd(ADDR_OSC_CTRL);
    check(16'(rd_val[LOCK_BIT]), 16'h0000);
    @(posedge clock_i);
    pll_lock_raw_i <= 1'b1;
    wait_lock(1'b1);
    check(16'(rd_val[LOCK_BIT]), 16'h0001);
    wr(ADDR_PLL_CFG, 16'h0000);
    rd(ADDR_OSC_CTRL);
    check(16'(rd_val[LOCK_BIT]), 16'h0000);
    rd(4'hc);
    check(rd_val, 16'h0000);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    srst_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    pll_lock_raw_i = 1'b0;
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    reset_test();
    power_up_delay_timer_test();
    select_test();
    trim_test();
    gain_lock_test();
    reset_test();
    stop_test();
  end
endmodule
